// File: rtl/ufc_pkg.sv
package ufc_pkg;

  // Register addresses on the 3-bit register port
  localparam logic [2:0] ADDR_INT_ENABLE  = 3'h0;
  localparam logic [2:0] ADDR_INT_IDENT   = 3'h1;
  localparam logic [2:0] ADDR_FEATURE     = 3'h2;
  localparam logic [2:0] ADDR_FIFO_CTRL   = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTRL  = 3'h4;
  localparam logic [2:0] ADDR_FLOW_THRESH = 3'h5;
  localparam logic [2:0] ADDR_PAUSE_CHAR  = 3'h6;

  // interrupt_enable fields
  localparam int IE_RX_DATA   = 0;
  localparam int IE_TX_SPACE  = 1;
  localparam int IE_LINE_STAT = 2;
  localparam int IE_MODEM     = 3;
  localparam int IE_SLEEP     = 4;
  localparam int IE_PAUSE_RX  = 5;
  localparam int IE_RTS_HIGH  = 6;
  localparam int IE_CTS_HIGH  = 7;

  // enhanced_feature_control fields
  localparam int EF_SWFLOW_LO = 0;
  localparam int EF_ENHANCED  = 4;
  localparam int EF_SPECIAL   = 5;
  localparam int EF_AUTO_RTS  = 6;
  localparam int EF_AUTO_CTS  = 7;

  // fifo_control and modem_control fields
  localparam int FC_ENABLE    = 0;
  localparam int MC_RTS       = 1;

  // Write masks of the fields guarded by the enhanced-functions bit, and of the implemented bits
  localparam logic [7:0] IE_PROT_MASK = 8'hf0;
  localparam logic [7:0] FC_PROT_MASK = 8'h30;
  localparam logic [7:0] MC_PROT_MASK = 8'he0;
  localparam logic [7:0] FC_IMPL_MASK = 8'h31;
  localparam logic [7:0] MC_IMPL_MASK = 8'he2;

  // Reset values
  localparam logic [7:0] IE_RESET     = 8'h00;
  localparam logic [7:0] EF_RESET     = 8'h00;
  localparam logic [7:0] FC_RESET     = 8'h00;
  localparam logic [7:0] MC_RESET     = 8'h00;
  localparam logic [7:0] TH_RESET     = 8'h00;
  localparam logic [7:0] PC_RESET     = 8'h00;

  // Identification codes on bits 5:0
  localparam logic [5:0] ID_LINE_STAT = 6'h06;
  localparam logic [5:0] ID_RX_TMO    = 6'h0c;
  localparam logic [5:0] ID_RX_DATA   = 6'h04;
  localparam logic [5:0] ID_TX_SPACE  = 6'h02;
  localparam logic [5:0] ID_MODEM     = 6'h00;
  localparam logic [5:0] ID_PAUSE_RX  = 6'h10;
  localparam logic [5:0] ID_FLOW_HIGH = 6'h20;
  localparam logic [5:0] ID_NONE      = 6'h01;

  // Threshold nibbles count in steps of four bytes
  localparam int TH_STEP_SHIFT = 2;
  localparam int LEVEL_W       = 7;

endpackage

// File: rtl/ufc_irq_feature_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module ufc_irq_feature_ctrl
  import ufc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  // Register port
  input  wire logic [2:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  // Interrupt sources from the channel datapath
  input  wire logic               line_status_err,
  input  wire logic               rx_timeout,
  input  wire logic               rx_data_ready,
  input  wire logic               tx_below_thresh,
  input  wire logic               modem_status_chg,
  input  wire logic               pause_char_rx,
  // Received characters
  input  wire logic               rx_char_valid,
  input  wire logic [7:0]         rx_char,
  input  wire logic [LEVEL_W-1:0] rx_fifo_level,
  // Modem pins
  input  wire logic               cts_n,
  output logic                    rts_n,
  // Channel outputs
  output logic                    irq,
  output logic                    tx_halt,
  output logic                    sleep_en,
  output logic      [3:0]         sw_flow_mode,
  output logic                    fifo_enable,
  output logic      [1:0]         fifo_prot_sel,
  output logic      [2:0]         modem_prot_sel,
  output logic      [7:0]         flow_thresholds,
  output logic      [7:0]         special_char_match
);

  typedef struct packed {
    logic [7:0] int_enable;
    logic [7:0] feature;
    logic [7:0] fifo_ctrl;
    logic [7:0] modem_ctrl;
    logic [7:0] flow_thresh;
    logic [7:0] pause_char;
    logic       tx_pend;
    logic       pause_pend;
    logic       cts_pend;
    logic       rts_pend;
    logic       tx_below_prev;
    logic       cts_meta;
    logic       cts_sync;
    logic       cts_prev;
    logic       rts_n;
    logic       tx_halt;
    logic       irq;
    logic [7:0] rdata;
    logic [7:0] match_cnt;
  } ufc_state_s;

  localparam ufc_state_s ST_RESET = '{
    int_enable:    IE_RESET,
    feature:       EF_RESET,
    fifo_ctrl:     FC_RESET,
    modem_ctrl:    MC_RESET,
    flow_thresh:   TH_RESET,
    pause_char:    PC_RESET,
    tx_pend:       1'b0,
    pause_pend:    1'b0,
    cts_pend:      1'b0,
    rts_pend:      1'b0,
    tx_below_prev: 1'b0,
    cts_meta:      1'b1,
    cts_sync:      1'b1,
    cts_prev:      1'b1,
    rts_n:         1'b1,
    tx_halt:       1'b0,
    irq:           1'b0,
    rdata:         8'h00,
    match_cnt:     8'h00
  };

  ufc_state_s st_q;
  ufc_state_s st_d;

  logic             ls_on;
  logic             tmo_on;
  logic             rxd_on;
  logic             tx_on;
  logic             ms_on;
  logic             pause_on;
  logic             flow_on;
  logic             any_on;
  logic [5:0]       id_code;
  logic [7:0]       id_byte;
  logic             id_read;
  logic [7:0]       wr_mask;
  logic [LEVEL_W-1:0] halt_lvl;
  logic [LEVEL_W-1:0] resume_lvl;
  logic             new_ie_tx;
  logic             spc_hit;

  // Enabled pending sources
  always_comb begin
    ls_on    = line_status_err & st_q.int_enable[IE_LINE_STAT];
    tmo_on   = rx_timeout & st_q.int_enable[IE_RX_DATA];
    rxd_on   = rx_data_ready & st_q.int_enable[IE_RX_DATA];
    tx_on    = st_q.tx_pend & st_q.int_enable[IE_TX_SPACE];
    ms_on    = modem_status_chg & st_q.int_enable[IE_MODEM];
    pause_on = st_q.pause_pend & st_q.int_enable[IE_PAUSE_RX];
    flow_on  = (st_q.cts_pend & st_q.int_enable[IE_CTS_HIGH]) |
               (st_q.rts_pend & st_q.int_enable[IE_RTS_HIGH]);
    any_on   = ls_on | tmo_on | rxd_on | tx_on | ms_on | pause_on |
               flow_on;
  end

  // Priority encoder, lowest level first
  always_comb begin
    if (ls_on) begin
      id_code = ID_LINE_STAT;
    end else if (tmo_on) begin
      id_code = ID_RX_TMO;
    end else if (rxd_on) begin
      id_code = ID_RX_DATA;
    end else if (tx_on) begin
      id_code = ID_TX_SPACE;
    end else if (ms_on) begin
      id_code = ID_MODEM;
    end else if (pause_on) begin
      id_code = ID_PAUSE_RX;
    end else if (flow_on) begin
      id_code = ID_FLOW_HIGH;
    end else begin
      id_code = ID_NONE;
    end
    id_byte = {{2{st_q.fifo_ctrl[FC_ENABLE]}}, id_code};
  end

  always_comb begin
    id_read    = reg_rd && (reg_addr == ADDR_INT_IDENT);
    halt_lvl   = LEVEL_W'(st_q.flow_thresh[3:0]) << TH_STEP_SHIFT;
    resume_lvl = LEVEL_W'(st_q.flow_thresh[7:4]) << TH_STEP_SHIFT;
    new_ie_tx  = reg_wr && (reg_addr == ADDR_INT_ENABLE) &&
                 reg_wdata[IE_TX_SPACE] &&
                 !st_q.int_enable[IE_TX_SPACE];
    spc_hit    = rx_char_valid && st_q.feature[EF_SPECIAL] &&
                 (rx_char == st_q.pause_char);
    if (st_q.feature[EF_ENHANCED]) begin
      wr_mask = 8'hff;
    end else begin
      wr_mask = 8'h00;
    end
  end

  always_comb begin
    st_d = st_q;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_INT_ENABLE: begin
          st_d.int_enable = (reg_wdata & ~IE_PROT_MASK) |
            (((reg_wdata & wr_mask) |
              (st_q.int_enable & ~wr_mask)) & IE_PROT_MASK);
        end
        ADDR_FEATURE: begin
          st_d.feature = reg_wdata;
        end
        ADDR_FIFO_CTRL: begin
          st_d.fifo_ctrl = ((reg_wdata & ~FC_PROT_MASK) |
            (((reg_wdata & wr_mask) |
              (st_q.fifo_ctrl & ~wr_mask)) & FC_PROT_MASK)) &
            FC_IMPL_MASK;
        end
        ADDR_MODEM_CTRL: begin
          st_d.modem_ctrl = ((reg_wdata & ~MC_PROT_MASK) |
            (((reg_wdata & wr_mask) |
              (st_q.modem_ctrl & ~wr_mask)) & MC_PROT_MASK)) &
            MC_IMPL_MASK;
        end
        ADDR_FLOW_THRESH: begin
          st_d.flow_thresh = reg_wdata;
        end
        ADDR_PAUSE_CHAR: begin
          st_d.pause_char = reg_wdata;
        end
        default: begin
          st_d.rdata = st_q.rdata;
        end
      endcase
    end

    // Read data, one cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        ADDR_INT_ENABLE:  st_d.rdata = st_q.int_enable;
        ADDR_INT_IDENT:   st_d.rdata = id_byte;
        ADDR_FEATURE:     st_d.rdata = st_q.feature;
        ADDR_FIFO_CTRL:   st_d.rdata = st_q.fifo_ctrl;
        ADDR_MODEM_CTRL:  st_d.rdata = st_q.modem_ctrl;
        ADDR_FLOW_THRESH: st_d.rdata = st_q.flow_thresh;
        ADDR_PAUSE_CHAR:  st_d.rdata = st_q.pause_char;
        default:          st_d.rdata = 8'h00;
      endcase
    end else begin
      st_d.rdata = 8'h00;
    end

    // Transmit-space pending: cleared by reading it out, set wins
    st_d.tx_below_prev = tx_below_thresh;
    if (id_read && (id_code == ID_TX_SPACE)) begin
      st_d.tx_pend = 1'b0;
    end
    if (!tx_below_thresh) begin
      st_d.tx_pend = 1'b0;
    end
    if (tx_below_thresh && (!st_q.tx_below_prev || new_ie_tx)) begin
      st_d.tx_pend = 1'b1;
    end

    // Pause or special character pending
    if (id_read && (id_code == ID_PAUSE_RX)) begin
      st_d.pause_pend = 1'b0;
    end
    if (spc_hit || pause_char_rx) begin
      st_d.pause_pend = 1'b1;
    end
    if (spc_hit) begin
      st_d.match_cnt = st_q.match_cnt + 8'h01;
    end

    // CTS pin synchroniser and rising-edge detect
    st_d.cts_meta = cts_n;
    st_d.cts_sync = st_q.cts_meta;
    st_d.cts_prev = st_q.cts_sync;
    if (id_read && (id_code == ID_FLOW_HIGH)) begin
      st_d.cts_pend = 1'b0;
      st_d.rts_pend = 1'b0;
    end
    if (st_q.cts_sync && !st_q.cts_prev) begin
      st_d.cts_pend = 1'b1;
    end

    // Hardware flow control
    st_d.tx_halt = st_q.feature[EF_AUTO_CTS] & st_q.cts_sync;
    if (st_q.feature[EF_AUTO_RTS]) begin
      if (rx_fifo_level >= halt_lvl) begin
        st_d.rts_n = 1'b1;
      end else if (rx_fifo_level <= resume_lvl) begin
        st_d.rts_n = 1'b0;
      end
    end else begin
      st_d.rts_n = ~st_q.modem_ctrl[MC_RTS];
    end
    if (st_d.rts_n && !st_q.rts_n) begin
      st_d.rts_pend = 1'b1;
    end

    st_d.irq = any_on;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RESET;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign reg_rdata          = st_q.rdata;
  assign rts_n              = st_q.rts_n;
  assign irq                = st_q.irq;
  assign tx_halt            = st_q.tx_halt;
  assign sleep_en           = st_q.int_enable[IE_SLEEP];
  assign sw_flow_mode       = st_q.feature[EF_SWFLOW_LO +: 4];
  assign fifo_enable        = st_q.fifo_ctrl[FC_ENABLE];
  assign fifo_prot_sel      = st_q.fifo_ctrl[5:4];
  assign modem_prot_sel     = st_q.modem_ctrl[7:5];
  assign flow_thresholds    = st_q.flow_thresh;
  assign special_char_match = st_q.match_cnt;

endmodule
`default_nettype wire

// File: testbench/ufc_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
module ufc_peer_model (
  // Bench side
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       hold_req,
  input  wire logic       send,
  input  wire logic [7:0] chr,
  // Device side
  input  wire logic       rts_n,
  output logic            cts_n,
  output logic            rx_char_valid,
  output logic [7:0]      rx_char
);
  assign cts_n = hold_req;
  // Peer only sends while allowed; idle data toggles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_char_valid <= 1'b0;
      rx_char <= 8'h00;
    end else begin
      rx_char_valid <= send & ~rts_n;
      rx_char <= (send & ~rts_n) ? chr : ~rx_char;
    end
  end
endmodule
`default_nettype wire

// File: testbench/ufc_irq_feature_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ufc_irq_checker
  import ufc_pkg::*;
(
  // Register port
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire logic [2:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  // Channel
  input wire logic               line_status_err,
  input wire logic               rx_char_valid,
  input wire logic [7:0]         rx_char,
  input wire logic [LEVEL_W-1:0] rx_fifo_level,
  input wire logic               cts_n,
  input wire logic               rts_n,
  input wire logic               irq,
  input wire logic               tx_halt,
  input wire logic               sleep_en,
  input wire logic               fifo_enable,
  input wire logic [7:0]         flow_thresholds,
  input wire logic [7:0]         special_char_match
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] ie_q, ef_q, pc_q;
  // Shadow of the written registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ie_q <= IE_RESET;
      ef_q <= EF_RESET;
      pc_q <= PC_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_INT_ENABLE)
        ie_q <= ef_q[EF_ENHANCED] ? reg_wdata : {ie_q[7:4], reg_wdata[3:0]};
      if (reg_addr == ADDR_FEATURE)
        ef_q <= reg_wdata;
      if (reg_addr == ADDR_PAUSE_CHAR)
        pc_q <= reg_wdata;
    end
  end
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
  ident_mirror_a: assert property (
    $past(reg_rd && reg_addr == ADDR_INT_IDENT)
    |-> reg_rdata[7:6] == {2{$past(fifo_enable)}}) else $error("bad mirror");
  line_first_a: assert property (
    reg_rd && reg_addr == ADDR_INT_IDENT && line_status_err && ie_q[2]
    |=> reg_rdata[5:0] == ID_LINE_STAT) else $error("line not first");
  irq_raise_a: assert property (
    line_status_err && ie_q[IE_LINE_STAT] |=> irq) else $error("no irq");
  irq_quiet_a: assert property (
    (ie_q & 8'hef) == 8'h00 |=> !irq) else $error("masked irq");
  sleep_lock_a: assert property (
    reg_wr && reg_addr == ADDR_INT_ENABLE && !ef_q[EF_ENHANCED]
    |=> $stable(sleep_en)) else $error("locked bit written");
  cts_halt_a: assert property (
    (ef_q[EF_AUTO_CTS] && cts_n) [*4] |-> tx_halt) else $error("no halt");
  rts_halt_a: assert property (
    ef_q[EF_AUTO_RTS] && rx_fifo_level >= {1'b0, flow_thresholds[3:0], 2'b00}
    |=> rts_n) else $error("rts not raised");
  rts_resume_a: assert property (
    ef_q[EF_AUTO_RTS] && rx_fifo_level <= {1'b0, flow_thresholds[7:4], 2'b00}
    |=> !rts_n) else $error("rts not dropped");
  special_cnt_a: assert property (
    ef_q[EF_SPECIAL] && rx_char_valid && rx_char == pc_q
    |=> special_char_match == $past(special_char_match) + 8'h01)
    else $error("match not counted");
  cover property (tx_halt);
  cover property (reg_rd && reg_addr == ADDR_INT_IDENT && line_status_err);
  cover property (rx_char_valid && rx_char == pc_q);
endmodule
bind ufc_irq_feature_ctrl ufc_irq_checker u_chk (
  .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .line_status_err, .rx_char_valid, .rx_char, .rx_fifo_level, .cts_n,
  .rts_n, .irq, .tx_halt, .sleep_en, .fifo_enable, .flow_thresholds,
  .special_char_match
);
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ufc_pkg::*;
  logic       ref_clk;
  logic       rst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       tx_below_thresh = 1'b0, pause_char_rx = 1'b0;
  logic       hold_req = 1'b0, send = 1'b0;
  logic       cts_n, rts_n, irq, tx_halt, sleep_en, rx_char_valid;
  logic       fifo_enable;
  logic       line_status_err, rx_timeout, rx_data_ready, modem_status_chg;
  logic [1:0] fifo_prot_sel;
  logic [2:0] reg_addr = 3'h0, modem_prot_sel;
  logic [3:0] lvl = 4'h0, sw_flow_mode;
  logic [7:0] reg_wdata = 8'h00, chr = 8'h00, reg_rdata, rx_char;
  logic [7:0] flow_thresholds, special_char_match;
  logic [LEVEL_W-1:0] rx_fifo_level = '0;
  int         err_total = 0, n_compared = 0, cyc = 0;
  logic [2:0] pa [3] = '{ADDR_INT_ENABLE, ADDR_FIFO_CTRL, ADDR_MODEM_CTRL};
  logic [7:0] pv [3] = '{8'hff, 8'h31, 8'he2};
  logic [7:0] pm [3] = '{IE_PROT_MASK, FC_PROT_MASK, MC_PROT_MASK};
  logic [7:0] idc [5] = '{8'hc6, 8'hcc, 8'hc4, 8'hc2, 8'hc0};
  logic [3:0] lv [5] = '{4'h7, 4'h3, 4'h1, 4'h1, 4'h0};
  assign {line_status_err, rx_timeout, rx_data_ready, modem_status_chg} = lvl;

  ufc_irq_feature_ctrl dut (
    .ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .line_status_err, .rx_timeout, .rx_data_ready,
    .tx_below_thresh, .modem_status_chg, .pause_char_rx, .rx_char_valid,
    .rx_char, .rx_fifo_level, .cts_n, .rts_n, .irq, .tx_halt, .sleep_en,
    .sw_flow_mode, .fifo_enable, .fifo_prot_sel, .modem_prot_sel,
    .flow_thresholds, .special_char_match
  );
  ufc_peer_model peer (
    .ref_clk, .rst_n, .hold_req, .send, .chr, .rts_n, .cts_n,
    .rx_char_valid, .rx_char
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] s, e, input string nm);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e, string nm);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, nm);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++)
      rchk(3'(a), (a == 1) ? 8'h01 : 8'h00, "reset");
    // A write while the clock enable is low must not land
    @(posedge ref_clk) clk_en <= 1'b0;
    wr(ADDR_FLOW_THRESH, 8'h5a);
    @(posedge ref_clk) clk_en <= 1'b1;
    rchk(ADDR_FLOW_THRESH, 8'h00, "frozen");
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 3; i++) begin
        wr(pa[i], pv[i]);
        rchk(pa[i], k ? pv[i] : pv[i] & ~pm[i], "guard");
      end
      wr(ADDR_FEATURE, 8'h1a);
    end
    chk({4'h0, sw_flow_mode}, 8'h0a, "swmode");
    chk({7'h0, sleep_en}, 8'h01, "sleep");
    chk({5'h0, modem_prot_sel}, 8'h07, "mprot");
    chk({6'h0, fifo_prot_sel}, 8'h03, "fprot");
    chk({7'h0, fifo_enable}, 8'h01, "fifo_en");
    wr(ADDR_INT_IDENT, 8'h55);
    @(posedge ref_clk) {lvl, tx_below_thresh} <= 5'h1f;
    tick(2);
    chk({7'h0, irq}, 8'h01, "irq_on");
    for (int i = 0; i < 5; i++) begin
      rchk(ADDR_INT_IDENT, idc[i], "ident");
      @(posedge ref_clk) lvl <= lv[i];
    end
    tick(2);
    chk({7'h0, irq}, 8'h00, "irq_off");
    rchk(ADDR_INT_IDENT, 8'hc1, "idle");
    wr(ADDR_INT_ENABLE, 8'hfd);
    wr(ADDR_INT_ENABLE, 8'hff);
    rchk(ADDR_INT_IDENT, 8'hc2, "tx_again");
    @(posedge ref_clk) pause_char_rx <= 1'b1;
    @(posedge ref_clk) pause_char_rx <= 1'b0;
    rchk(ADDR_INT_IDENT, 8'hd0, "pause");
    wr(ADDR_FEATURE, 8'h9a);
    @(posedge ref_clk) hold_req <= 1'b1;
    tick(4);
    chk({7'h0, tx_halt}, 8'h01, "halt");
    rchk(ADDR_INT_IDENT, 8'he0, "cts_up");
    @(posedge ref_clk) hold_req <= 1'b0;
    wr(ADDR_FLOW_THRESH, 8'h28);
    chk(flow_thresholds, 8'h28, "thresh");
    wr(ADDR_FEATURE, 8'hfa);
    @(posedge ref_clk) rx_fifo_level <= 7'h20;
    tick(2);
    chk({7'h0, rts_n}, 8'h01, "rts_halt");
    @(posedge ref_clk) rx_fifo_level <= 7'h08;
    tick(2);
    chk({7'h0, rts_n}, 8'h00, "rts_resume");
    wr(ADDR_PAUSE_CHAR, 8'h13);
    @(posedge ref_clk) {send, chr} <= 9'h111;
    @(posedge ref_clk) chr <= 8'h13;
    @(posedge ref_clk) send <= 1'b0;
    tick(2);
    chk(special_char_match, 8'h01, "special");
    rchk(ADDR_INT_IDENT, 8'hd0, "special_id");
    print_verdict();
  end
endmodule
`default_nettype wire
